/* File: rtl/core_clock_cfg.svh */
// Constants for the core clock ratio and reset sequencer
`ifndef CORE_CLOCK_CFG_SVH
`define CORE_CLOCK_CFG_SVH
`define RATIO_SEL_W 3
`define RATIO_CNT_W 4
`define RATIO_CODE_4 3'h0
`define RATIO_CODE_5 3'h1
`define RATIO_CODE_6 3'h2
`define RATIO_CODE_7 3'h3
`define RATIO_CODE_8 3'h4
`define RATIO_CODE_10 3'h5
`define RATIO_CODE_12 3'h6
`define RATIO_CODE_RSVD 3'h7
`define RATIO_DEFAULT 4'h4
`define SEQ_CNT_W 8
`define RESET_SEQ_CYCLES 8'h10
`define DRAM_INIT_CYCLES 8'h08
`endif

/* File: rtl/core_clock_pkg.sv */
// Types for the core clock ratio and reset sequencer
package core_clock_pkg;
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_SEQ = 4'b0010,
    ST_DRAM = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_t;
endpackage

/* File: rtl/sync2.sv */
// Two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: rtl/core_clock_ratio_reset.sv */
// Core clock ratio decode, reset sequencing and output three-state control
// Behaviour
// - Core clock runs at system clock divided by n, n from strap 000..110 as 4,5,6,7,8,10,12.
// - The system clock is the bus clock and the reference for the core clock.
// - Asynchronous inputs pass a two-flop synchroniser before use.
// - Output pins (pin_out, via pin_oe_n) are released to high impedance while reset is active.
// - Outputs can also be released to high impedance in normal operation.
// - Reset forces the logic to a known state with execution idle.
// - A reset-complete output signals the end of the internal reset sequence.
// - The power-on reset input, looped from reset-complete, resets internal DRAM.
`timescale 1ns/1ps
`include "core_clock_cfg.svh"
module core_clock_ratio_reset
  import core_clock_pkg::*;
#(
  parameter int NUM_OUT = 8,
  parameter logic [`SEQ_CNT_W-1:0] SEQ_CYCLES = `RESET_SEQ_CYCLES,
  parameter logic [`SEQ_CNT_W-1:0] DRAM_CYCLES = `DRAM_INIT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`RATIO_SEL_W-1:0] core_clock_ratio_select,
  input wire logic reset_in_n,
  input wire logic por_in_n,
  input wire logic out_release,
  input wire logic [NUM_OUT-1:0] pin_out_d,
  output logic [NUM_OUT-1:0] pin_out,
  output logic [NUM_OUT-1:0] pin_oe_n,
  output logic reset_out_n,
  output logic dram_reset_n,
  output logic core_clock,
  output logic instr_strobe,
  output logic [`RATIO_CNT_W-1:0] ratio,
  output logic ratio_reserved,
  output logic run
);
  // Sequencer and strap capture
  seq_state_t state_q, state_d;
  logic [`SEQ_CNT_W-1:0] cnt_q, cnt_d;
  logic [`RATIO_SEL_W-1:0] sel_q;
  logic [`RATIO_CNT_W-1:0] ratio_q;
  logic rsvd_q;
  logic [`RATIO_CNT_W-1:0] ratio_dec;

  // Synchronised pin levels
  logic [1:0] async_raw;
  logic [1:0] async_sync;
  logic rst_in_s;
  logic por_s;

  // Clock phase and output flops
  logic [`RATIO_CNT_W-1:0] ph_q;
  logic [NUM_OUT-1:0] out_q;
  logic oe_n_q;
  logic rst_done_q;
  logic run_q;
  logic core_q;
  logic strobe_q;

  // Decode helpers
  logic [`RATIO_CNT_W-1:0] ratio_m1;
  logic [`RATIO_CNT_W-1:0] ratio_half;
  logic ph_wrap;
  logic seq_done;

  // Reset and power-on pins are asynchronous, so synchronise them first
  assign async_raw = {reset_in_n, por_in_n};
  sync2 #(.W(2), .RST_VAL(2'b00)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(async_raw),
    .sync_out(async_sync)
  );
  assign rst_in_s = ~async_sync[1];
  assign por_s = ~async_sync[0];

  // Strap decode; reserved code falls back to the default ratio
  assign ratio_dec = (sel_q == `RATIO_CODE_4) ? 4'h4 :
                     (sel_q == `RATIO_CODE_5) ? 4'h5 :
                     (sel_q == `RATIO_CODE_6) ? 4'h6 :
                     (sel_q == `RATIO_CODE_7) ? 4'h7 :
                     (sel_q == `RATIO_CODE_8) ? 4'h8 :
                     (sel_q == `RATIO_CODE_10) ? 4'hA :
                     (sel_q == `RATIO_CODE_12) ? 4'hC : `RATIO_DEFAULT;

  // Straps are caught only during reset; board keeps them static anyway
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q <= `RATIO_CODE_4;
      ratio_q <= `RATIO_DEFAULT;
      rsvd_q <= 1'b0;
    end else if (state_q == ST_RESET) begin
      sel_q <= core_clock_ratio_select;
      ratio_q <= ratio_dec;
      rsvd_q <= (sel_q == `RATIO_CODE_RSVD);
    end
  end

  // Core clock phase counter, one period per ratio system clocks
  assign ratio_m1 = ratio_q - 4'h1;
  assign ratio_half = ratio_q >> 1;
  // Wrap on >= so a smaller ratio caught in reset cannot run the count past its end
  assign ph_wrap = (ph_q >= ratio_m1);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ph_q <= '0;
    end else if (ph_wrap) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end

  // Core clock level and instruction strobe; strobe stays low unless running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      core_q <= (ph_q < ratio_half);
      strobe_q <= ph_wrap && run_q;
    end
  end

  // Reset sequencer: reset -> internal sequence -> DRAM init -> run
  assign seq_done = (cnt_q == '0);
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (rst_in_s) begin
      state_d = ST_RESET;
      cnt_d = SEQ_CYCLES;
    end else begin
      case (state_q)
        ST_RESET: begin
          // One settling cycle before the count starts
          state_d = ST_SEQ;
          cnt_d = SEQ_CYCLES;
        end
        ST_SEQ: begin
          if (seq_done) begin
            state_d = ST_DRAM;
            cnt_d = DRAM_CYCLES;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        ST_DRAM: begin
          // DRAM init only counts once looped-back power-on reset is released
          if (por_s) begin
            cnt_d = DRAM_CYCLES;
          end else if (seq_done) begin
            state_d = ST_RUN;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        ST_RUN: begin
          // Held until the reset pin is seen again
          state_d = ST_RUN;
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
  end

  // State and count register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_RESET;
      cnt_q <= SEQ_CYCLES;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Status flops; reset-complete rises once the sequence leaves ST_SEQ
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_done_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      rst_done_q <= (state_d == ST_DRAM) || (state_d == ST_RUN);
      run_q <= (state_d == ST_RUN);
    end
  end

  // Output pins: registered data, released during reset or on request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      out_q <= pin_out_d;
      oe_n_q <= !run_q || rst_in_s || out_release;
    end
  end

  // Pin drivers; one enable flop so every pin releases together
  assign pin_out = out_q;
  assign pin_oe_n = {NUM_OUT{oe_n_q}};

  // Reset handshake; DRAM reset follows the looped-back pin after sync
  assign reset_out_n = rst_done_q;
  assign dram_reset_n = ~por_s;

  // Clock and status outputs, all straight from flops
  assign core_clock = core_q;
  assign instr_strobe = strobe_q;
  assign ratio = ratio_q;
  assign ratio_reserved = rsvd_q;
  assign run = run_q;
endmodule

/* File: tb/board_model.sv */
// Board reset source with minimum hold and reset loopback
`timescale 1ns/1ps
module board_model (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic reset_out_n,
  output logic reset_in_n,
  output logic por_in_n
);
  logic [3:0] hold_q = 4'h8;
  // Hold counter, so a short request still gives a full reset
  always_ff @(posedge clk) begin
    hold_q <= rst_req ? 4'h8 : hold_q - {3'h0, hold_q != 4'h0};
  end
  assign reset_in_n = !rst_req && hold_q == 4'h0;
  assign por_in_n = reset_out_n;
endmodule

/* File: tb/core_clock_ratio_reset_chk.sv */
// Port checker for the clock ratio and reset block
`timescale 1ns/1ps
`include "core_clock_cfg.svh"
module core_clock_ratio_reset_chk #(
  parameter int NUM_OUT = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`RATIO_SEL_W-1:0] core_clock_ratio_select,
  input wire logic reset_in_n,
  input wire logic por_in_n,
  input wire logic out_release,
  input wire logic [NUM_OUT-1:0] pin_oe_n,
  input wire logic reset_out_n,
  input wire logic dram_reset_n,
  input wire logic instr_strobe,
  input wire logic [`RATIO_CNT_W-1:0] ratio,
  input wire logic run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [3:0] gap_q;
  logic seen_q;
  function automatic logic [3:0] exp_r(input logic [2:0] s);
    case (s)
      3'h5: return 4'ha;
      3'h6: return 4'hc;
      3'h7: return 4'h4;
      default: return {1'b0, s} + 4'h4;
    endcase
  endfunction
  // Cycles since last strobe; first period after start is partial
  always_ff @(posedge clk) begin
    seen_q <= (rstn && run) && (seen_q || instr_strobe);
    gap_q <= instr_strobe ? 4'h1 : gap_q + 4'h1;
  end
  a_oe_idle: assert property (!run && !$past(run) |-> &pin_oe_n) else $error("pins driven");
  a_oe_release: assert property (out_release |=> &pin_oe_n) else $error("no release");
  a_ratio_map: assert property (run |-> ratio == exp_r(core_clock_ratio_select)) else $error("ratio");
  a_strobe_gap: assert property (instr_strobe && run && seen_q |-> gap_q == ratio) else $error("gap");
  a_sync_stage: assert property ($fell(reset_in_n) && run |=> run ##[1:4] !run) else $error("sync");
  a_idle_reset: assert property (!reset_in_n [*6] |-> !run && !instr_strobe) else $error("idle");
  a_done_first: assert property (run |-> reset_out_n && dram_reset_n) else $error("order");
  a_dram_follow: assert property (!por_in_n [*3] |-> !dram_reset_n) else $error("dram");
  a_seq_wait: assert property ($rose(reset_in_n) |-> !reset_out_n [*8]) else $error("early");
endmodule
bind core_clock_ratio_reset core_clock_ratio_reset_chk #(.NUM_OUT(NUM_OUT)) chk (.clk(clk),
  .rstn(rstn), .core_clock_ratio_select(core_clock_ratio_select), .reset_in_n(reset_in_n),
  .por_in_n(por_in_n), .out_release(out_release), .pin_oe_n(pin_oe_n), .ratio(ratio),
  .reset_out_n(reset_out_n), .dram_reset_n(dram_reset_n), .instr_strobe(instr_strobe), .run(run));

/* File: tb/tb.sv */
// Bench for the clock ratio and reset block
`timescale 1ns/1ps
module tb;
  logic clk = 0, rstn = 0, rst_req = 0, out_release = 0;
  logic [2:0] sel = 3'h0;
  logic [7:0] pd = 8'h5a, pin_out, pin_oe_n;
  logic [3:0] ratio;
  logic reset_in_n, por_in_n, reset_out_n, dram_reset_n, core_clock, instr_strobe, rsv, run;
  int fail_count = 0, n_tests = 0;
  logic [3:0] exp_tab [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
  initial forever #5 clk = ~clk;
  board_model bm (.clk(clk), .rst_req(rst_req), .reset_out_n(reset_out_n),
    .reset_in_n(reset_in_n), .por_in_n(por_in_n));
  core_clock_ratio_reset dut (.clk(clk), .rstn(rstn), .core_clock_ratio_select(sel),
    .reset_in_n(reset_in_n), .por_in_n(por_in_n), .out_release(out_release), .pin_out_d(pd),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .reset_out_n(reset_out_n), .ratio(ratio),
    .dram_reset_n(dram_reset_n), .core_clock(core_clock), .instr_strobe(instr_strobe),
    .ratio_reserved(rsv), .run(run));
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Values are copied at the call; the compare only runs 1 ns later
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1 n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Poll one step after each edge, never in the edge's own time step
  task automatic wait_hi(input bit strobe);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while ((strobe ? instr_strobe : run) !== 1'b1 && i < 400);
    if ((strobe ? instr_strobe : run) !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Straps only change under power reset
  task automatic power_up(input logic [2:0] code);
    @(posedge clk);
    rstn <= 1'b0;
    sel <= code;
    repeat (20) @(posedge clk);
    chk(pin_oe_n, 8'hff);
    chk({6'h00, reset_out_n, run}, 8'h00);
    @(posedge clk) rstn <= 1'b1;
    wait_hi(0);
  endtask
  task automatic ratio_scan();
    int n;
    int hi;
    for (int c = 0; c < 8; c++) begin
      power_up(c[2:0]);
      chk({4'h0, ratio}, {4'h0, exp_tab[c]});
      chk({7'h00, rsv}, {7'h00, c == 7});
      chk({6'h00, reset_out_n, dram_reset_n}, 8'h03);
      wait_hi(1);
      n = 0;
      hi = 0;
      // Core clock sits high for half of each strobe period, rounded down
      do begin
        #10 n++;
        hi += int'(core_clock);
      end while (instr_strobe !== 1'b1 && n < 20);
      chk(n[7:0], {4'h0, exp_tab[c]});
      chk(hi[7:0], {4'h0, exp_tab[c] >> 1});
    end
  endtask
  task automatic release_and_warm();
    @(posedge clk) out_release <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pin_oe_n, 8'hff);
    @(posedge clk) out_release <= 1'b0;
    pd <= 8'ha5;
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 8'h00);
    chk(pin_out, 8'ha5);
    @(posedge clk) rst_req <= 1'b1;
    @(posedge clk) rst_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk({5'h00, reset_out_n, run, pin_oe_n[0]}, 8'h01);
    wait_hi(0);
    chk({7'h00, reset_out_n}, 8'h01);
  endtask
  initial begin
    ratio_scan();
    release_and_warm();
    stop_test();
  end
endmodule
